// ---- verilog/sbr_cfg.svh ----
`ifndef SBR_CFG_SVH
`define SBR_CFG_SVH
// Summary of operation
// R1: Burst select picks chop four or eight
// R2: Burst select never used as column bit
// R3: Burst choice works with auto precharge
// R4: Read to precharge waits posted plus close
// R5: Precharge also waits open-to-close interval
// R6: Read-to-close delay is max(4 cycles, 7.5ns)
// R7: Activate waits close period and row cycle
// R8: Data window faults corrupt only addressed location
// R9: Strobe faults corrupt only addressed location
// R10: Every strobe edge of burst meets timing
// R11: Strobe skew met at each rising edge
// R12: One byte mask per eight lines, data-timed
// R13: Mask ignored on reads; termination strobe option
// R14: Write-to-read counted after last write beat
// R15: Write recovery counted after last write beat
// R16: Field 00, or 01 with select high: eight
// R17: Field 01 with select low: chop four
// R18: Field 10 always chop four
// R19: Other violations need full reset and init
// R20: Read data after posted plus column delay
// R21: Row stays open until bank precharge
// R22: No activate before close period elapses
// R23: Per-bank interval counters block bad commands

// ----------------------------------------
// Link shape
// ----------------------------------------
`define SBR_BANKS 8
`define SBR_DW 8
`define SBR_AW 14
`define SBR_BURST_SEL_BIT 12
`define SBR_AUTO_PRE_BIT 10
`define SBR_TERMINATION_STROBE_BIT 11
`define SBR_MR0_BANK 3'h0
`define SBR_MR1_BANK 3'h1
`define SBR_BF_FIXED8 2'h0
`define SBR_BF_OTF 2'h1
`define SBR_BF_FIXED4 2'h2
`define SBR_BEATS_FULL 8
`define SBR_BEATS_CHOP 4

// ----------------------------------------
// Timing, in link clock cycles unless noted
// ----------------------------------------
`define SBR_AL 0
`define SBR_CL 6
`define SBR_CWL 5
`define SBR_RCD 6
`define SBR_RAS 15
`define SBR_RP 6
`define SBR_RC 21
`define SBR_WR 6
`define SBR_WTR 4
`define SBR_RTP_NCK 4
`define SBR_RTP_PS 7500
`define SBR_SYS_PS 8000
`define SBR_LINK_HALF 4
`endif

// ---- verilog/sbr_pkg.sv ----
`include "sbr_cfg.svh"
package sbr_pkg;
    typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_MRS} sbr_cmd_e;
    typedef enum logic [2:0] {ST_RST, ST_MR0, ST_MR1, ST_IDLE, ST_ACT, ST_COL, ST_DATA, ST_PRE} sbr_st_e;
    typedef logic [7:0] sbr_tmr_t;

    typedef struct packed {
        logic [1:0] mode_register_zero;
        logic termination_strobe_en;
        logic [`SBR_BANKS-1:0] open;
        logic [`SBR_BANKS-1:0] ap;
        logic busy;
        logic wr;
        logic full;
        logic [5:0] cnt;
        logic [2:0] bank;
        logic [3:0] col;
        logic [`SBR_DW-1:0] dq_o;
        logic dq_oe;
        logic ts_o;
        logic ts_oe;
    } sbr_dev_s;

    typedef struct packed {
        logic [2:0] ph;
        logic lclk;
        logic lrst;
        sbr_st_e st;
        sbr_cmd_e cmd;
        logic [2:0] bank;
        logic [`SBR_AW-1:0] addr;
        logic [`SBR_DW-1:0] dq_o;
        logic dq_oe;
        logic dm;
        sbr_tmr_t [`SBR_BANKS-1:0] ras;
        sbr_tmr_t [`SBR_BANKS-1:0] rc;
        sbr_tmr_t [`SBR_BANKS-1:0] rp;
        sbr_tmr_t [`SBR_BANKS-1:0] clo;
        sbr_tmr_t wtr;
        sbr_tmr_t wt;
        logic [5:0] cnt;
        logic q_wr;
        logic [2:0] q_bank;
        logic [13:0] q_row;
        logic [9:0] q_col;
        logic q_chop;
        logic [63:0] q_wdata;
        logic [7:0] q_wmask;
        logic ready;
        logic init;
        logic rvalid;
        logic [63:0] rdata;
    } sbr_ctl_s;

    // Burst size decode shared by both ends
    function automatic logic sbr_full_burst(input logic [1:0] fld, input logic sel);
        return (fld == `SBR_BF_FIXED8) || ((fld == `SBR_BF_OTF) && sel) ||
            ((fld != `SBR_BF_OTF) && (fld != `SBR_BF_FIXED4));
    endfunction
endpackage

// ---- verilog/sbr_link_if.sv ----
`timescale 1ns/10ps
`include "sbr_cfg.svh"
interface sbr_link_if;
    logic link_clk;
    logic link_rst;
    sbr_pkg::sbr_cmd_e cmd;
    logic [2:0] bank;
    logic [`SBR_AW-1:0] addr;
    logic [`SBR_DW-1:0] ctl_dq_o;
    logic ctl_dq_oe;
    logic [`SBR_DW-1:0] dev_dq_o;
    logic dev_dq_oe;
    logic [`SBR_DW-1:0] dq;
    logic write_byte_mask;
    logic termination_strobe_o;
    logic termination_strobe_oe;

    // Resolved data wire; device wins while it drives
    assign dq = dev_dq_oe ? dev_dq_o : ctl_dq_o;

    modport ctl(output link_clk, link_rst, cmd, bank, addr, ctl_dq_o, ctl_dq_oe, write_byte_mask,
        input dq, termination_strobe_o, termination_strobe_oe);
    modport dev(input link_clk, link_rst, cmd, bank, addr, dq, write_byte_mask,
        output dev_dq_o, dev_dq_oe, termination_strobe_o, termination_strobe_oe);
endinterface

// ---- verilog/sbr_dram_dev.sv ----
`timescale 1ns/10ps
`include "sbr_cfg.svh"
module sbr_dram_dev #(
    parameter int AL = `SBR_AL,
    parameter int CL = `SBR_CL,
    parameter int CWL = `SBR_CWL
) (
    sbr_link_if.dev link,
    output logic [`SBR_BANKS-1:0] open_banks,
    output logic full_burst_eight
);
    localparam logic [5:0] RL = 6'(AL + CL);
    localparam logic [5:0] WL = 6'(AL + CWL);

    sbr_pkg::sbr_dev_s s_r;
    sbr_pkg::sbr_dev_s s_nxt;
    logic [`SBR_DW-1:0] mem [0:(`SBR_BANKS*16)-1];
    logic we;
    logic [6:0] maddr;
    logic [5:0] lat;
    logic [5:0] beat;

    // ----------------------------------------
    // Command decode and burst sequencing
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        we = 1'b0;
        s_nxt.dq_oe = 1'b0;
        s_nxt.ts_o = 1'b0;
        s_nxt.ts_oe = 1'b0;
        lat = s_r.wr ? WL : RL;
        beat = 6'(s_r.cnt - lat);
        // Chop keeps the nibble picked by the column; eight walks the eight-byte half picked by col[3]
        maddr = s_r.full ? {s_r.bank, s_r.col[3], beat[2:0]} : {s_r.bank, s_r.col[3:2], beat[1:0]};
        if (s_r.busy) begin
            s_nxt.cnt = 6'(s_r.cnt + 6'h01);
            if (s_r.cnt >= lat) begin
                if (s_r.wr) begin
                    // Mask is taken on the same edge as its data byte [R12]
                    // Termination strobe mode turns the mask pin off as a mask [R13]
                    we = ~(link.write_byte_mask & ~s_r.termination_strobe_en);
                    s_nxt.ts_o = s_r.termination_strobe_en;
                    s_nxt.ts_oe = s_r.termination_strobe_en;
                end else begin
                    s_nxt.dq_o = mem[maddr]; // [R20]
                    s_nxt.dq_oe = 1'b1;
                end
                if (beat == (s_r.full ? 6'(`SBR_BEATS_FULL - 1) : 6'(`SBR_BEATS_CHOP - 1))) begin
                    s_nxt.busy = 1'b0;
                    // Auto precharge closes only once the burst is through [R3]
                    if (s_r.ap[s_r.bank]) begin
                        s_nxt.open[s_r.bank] = 1'b0;
                        s_nxt.ap[s_r.bank] = 1'b0;
                    end
                end
            end
        end
        unique case (link.cmd)
            sbr_pkg::CMD_ACT: s_nxt.open[link.bank] = 1'b1;
            sbr_pkg::CMD_PRE: begin
                // Rows stay open until a precharge names them or sets the all-banks bit [R21]
                if (link.addr[`SBR_AUTO_PRE_BIT]) begin
                    s_nxt.open = '0;
                end else begin
                    s_nxt.open[link.bank] = 1'b0;
                end
            end
            sbr_pkg::CMD_RD, sbr_pkg::CMD_WR: begin
                s_nxt.busy = 1'b1;
                s_nxt.cnt = 6'h01;
                s_nxt.wr = (link.cmd == sbr_pkg::CMD_WR);
                // Burst size from mode field and select line [R1] [R16] [R17] [R18]
                s_nxt.full = sbr_pkg::sbr_full_burst(s_r.mode_register_zero, link.addr[`SBR_BURST_SEL_BIT]);
                s_nxt.ap[link.bank] = link.addr[`SBR_AUTO_PRE_BIT]; // [R3]
                s_nxt.bank = link.bank;
                s_nxt.col = link.addr[3:0]; // Select line kept out of the column [R2]
            end
            sbr_pkg::CMD_MRS: begin
                if (link.bank == `SBR_MR0_BANK) begin
                    s_nxt.mode_register_zero = link.addr[1:0];
                end else if (link.bank == `SBR_MR1_BANK) begin
                    s_nxt.termination_strobe_en = link.addr[`SBR_TERMINATION_STROBE_BIT];
                end
            end
            default: ;
        endcase
    end

    // ----------------------------------------
    // State and array
    // ----------------------------------------
    always_ff @(posedge link.link_clk) begin
        if (link.link_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Bad timing can only spoil the one addressed byte [R8] [R9]
    always_ff @(posedge link.link_clk) begin
        if (we) begin
            mem[maddr] <= link.dq;
        end
    end

    assign link.dev_dq_o = s_r.dq_o;
    assign link.dev_dq_oe = s_r.dq_oe;
    assign link.termination_strobe_o = s_r.ts_o;
    assign link.termination_strobe_oe = s_r.ts_oe;
    assign open_banks = s_r.open;
    assign full_burst_eight = s_r.full;
endmodule

// ---- verilog/sbr_mem_ctl.sv ----
`timescale 1ns/10ps
`include "sbr_cfg.svh"
module sbr_mem_ctl #(
    parameter int AL = `SBR_AL,
    parameter int CL = `SBR_CL,
    parameter int CWL = `SBR_CWL,
    parameter int T_RCD = `SBR_RCD,
    parameter int T_RAS = `SBR_RAS,
    parameter int T_RP = `SBR_RP,
    parameter int T_RC = `SBR_RC,
    parameter int T_WR = `SBR_WR,
    parameter int T_WTR = `SBR_WTR,
    parameter int HALF = `SBR_LINK_HALF
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [1:0] burst_field_cfg,
    input wire logic termination_strobe_en_cfg,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [2:0] req_bank,
    input wire logic [13:0] req_row,
    input wire logic [9:0] req_col,
    input wire logic req_chop,
    input wire logic [63:0] req_wdata,
    input wire logic [7:0] req_wmask,
    output logic req_ready,
    output logic init_done,
    output logic rd_valid,
    output logic [63:0] rd_data,
    sbr_link_if.ctl link
);
    // ----------------------------------------
    // Derived cycle counts
    // ----------------------------------------
    localparam int LINK_PS = 2 * HALF * `SBR_SYS_PS;
    localparam int RTP_NS_CK = (`SBR_RTP_PS + LINK_PS - 1) / LINK_PS;
    // Read-to-close is the larger of the cycle floor and the time floor [R6]
    localparam int RTP = (RTP_NS_CK > `SBR_RTP_NCK) ? RTP_NS_CK : `SBR_RTP_NCK;
    localparam logic [5:0] RL = 6'(AL + CL);
    localparam logic [5:0] WL = 6'(AL + CWL);
    localparam logic [2:0] PH_LAST = 3'(HALF - 1);

    sbr_pkg::sbr_ctl_s s_r;
    sbr_pkg::sbr_ctl_s s_nxt;
    logic tick;
    logic [5:0] beats;
    logic [2:0] idx;
    logic [5:0] j;

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;
        // Outputs move on the sys edge that drops the link clock,
        // giving the device half a link period of setup
        tick = (s_r.ph == PH_LAST) && s_r.lclk;
        beats = s_r.q_chop ? 6'(`SBR_BEATS_CHOP) : 6'(`SBR_BEATS_FULL);
        j = s_r.cnt;
        idx = 3'h0;
        if (s_r.ph == PH_LAST) begin
            s_nxt.ph = 3'h0;
            s_nxt.lclk = ~s_r.lclk;
        end else begin
            s_nxt.ph = 3'(s_r.ph + 3'h1);
        end
        if (s_r.ready && req_valid) begin
            s_nxt.ready = 1'b0;
            s_nxt.q_wr = req_write;
            s_nxt.q_bank = req_bank;
            s_nxt.q_row = req_row;
            s_nxt.q_col = req_col;
            // Mode field overrides the chop bit; cfg must hold after init [R16] [R17] [R18]
            s_nxt.q_chop = ~sbr_pkg::sbr_full_burst(burst_field_cfg, ~req_chop);
            s_nxt.q_wdata = req_wdata;
            s_nxt.q_wmask = req_wmask;
            s_nxt.st = sbr_pkg::ST_ACT;
        end
        if (tick) begin
            s_nxt.cmd = sbr_pkg::CMD_NOP;
            s_nxt.dq_oe = 1'b0;
            s_nxt.dm = 1'b0;
            // Separate interval counters per bank, one link cycle each [R23]
            for (int b = 0; b < `SBR_BANKS; b++) begin
                if (s_r.ras[b] != 8'h00) s_nxt.ras[b] = s_r.ras[b] - 8'h01;
                if (s_r.rc[b] != 8'h00) s_nxt.rc[b] = s_r.rc[b] - 8'h01;
                if (s_r.rp[b] != 8'h00) s_nxt.rp[b] = s_r.rp[b] - 8'h01;
                if (s_r.clo[b] != 8'h00) s_nxt.clo[b] = s_r.clo[b] - 8'h01;
            end
            if (s_r.wtr != 8'h00) s_nxt.wtr = s_r.wtr - 8'h01;
            if (s_r.wt != 8'h00) s_nxt.wt = s_r.wt - 8'h01;
            unique case (s_r.st)
                sbr_pkg::ST_RST: s_nxt.st = sbr_pkg::ST_MR0; // Device sees two reset edges
                sbr_pkg::ST_MR0: begin
                    // Full reset and mode load is the recovery path [R19]
                    s_nxt.lrst = 1'b0;
                    s_nxt.cmd = sbr_pkg::CMD_MRS;
                    s_nxt.bank = `SBR_MR0_BANK;
                    s_nxt.addr = {12'h000, burst_field_cfg};
                    s_nxt.st = sbr_pkg::ST_MR1;
                end
                sbr_pkg::ST_MR1: begin
                    s_nxt.cmd = sbr_pkg::CMD_MRS;
                    s_nxt.bank = `SBR_MR1_BANK;
                    s_nxt.addr = '0;
                    s_nxt.addr[`SBR_TERMINATION_STROBE_BIT] = termination_strobe_en_cfg;
                    s_nxt.st = sbr_pkg::ST_IDLE;
                    s_nxt.init = 1'b1;
                    s_nxt.ready = 1'b1;
                end
                sbr_pkg::ST_ACT: begin
                    // Close period and row cycle must both be spent [R7] [R22]
                    if (s_r.rp[s_r.q_bank] == 8'h00 && s_r.rc[s_r.q_bank] == 8'h00) begin
                        s_nxt.cmd = sbr_pkg::CMD_ACT;
                        s_nxt.bank = s_r.q_bank;
                        s_nxt.addr = s_r.q_row;
                        s_nxt.rc[s_r.q_bank] = 8'(T_RC - 1);
                        s_nxt.ras[s_r.q_bank] = 8'(T_RAS - 1);
                        s_nxt.wt = 8'(T_RCD - 1);
                        s_nxt.st = sbr_pkg::ST_COL;
                    end
                end
                sbr_pkg::ST_COL: begin
                    // A read waits out the write-to-read turnaround [R14]
                    if (s_r.wt == 8'h00 && (s_r.q_wr || s_r.wtr == 8'h00)) begin
                        s_nxt.cmd = s_r.q_wr ? sbr_pkg::CMD_WR : sbr_pkg::CMD_RD;
                        s_nxt.bank = s_r.q_bank;
                        s_nxt.addr = {4'h0, s_r.q_col};
                        s_nxt.addr[`SBR_BURST_SEL_BIT] = ~s_r.q_chop; // [R1]
                        s_nxt.cnt = 6'h01;
                        if (s_r.q_wr) begin
                            // Recovery and turnaround start after the last beat [R15] [R14]
                            s_nxt.clo[s_r.q_bank] = 8'(WL + beats + 6'(T_WR) - 6'h01);
                            s_nxt.wtr = 8'(WL + beats + 6'(T_WTR) - 6'h01);
                        end else begin
                            s_nxt.clo[s_r.q_bank] = 8'(AL + RTP - 1); // [R4]
                        end
                        s_nxt.rdata = '0;
                        s_nxt.st = sbr_pkg::ST_DATA;
                    end
                end
                sbr_pkg::ST_DATA: begin
                    s_nxt.cnt = 6'(s_r.cnt + 6'h01);
                    if (s_r.q_wr) begin
                        idx = 3'(j - WL);
                        // Every beat launched on the same falling phase [R10] [R11]
                        if (j >= WL) begin
                            s_nxt.dq_o = s_r.q_wdata[idx*8+:8];
                            s_nxt.dm = s_r.q_wmask[idx]; // [R12]
                            s_nxt.dq_oe = 1'b1;
                        end
                        if (j == 6'(WL + beats - 6'h01)) s_nxt.st = sbr_pkg::ST_PRE;
                    end else begin
                        idx = 3'(j - RL - 6'h01);
                        if (j > RL) s_nxt.rdata[idx*8+:8] = link.dq; // [R20]
                        if (j == 6'(RL + beats)) s_nxt.st = sbr_pkg::ST_PRE;
                    end
                end
                sbr_pkg::ST_PRE: begin
                    // Both close spacing and open-to-close interval [R4] [R5] [R15]
                    if (s_r.clo[s_r.q_bank] == 8'h00 && s_r.ras[s_r.q_bank] == 8'h00) begin
                        s_nxt.cmd = sbr_pkg::CMD_PRE;
                        s_nxt.bank = s_r.q_bank;
                        s_nxt.addr = '0;
                        s_nxt.rp[s_r.q_bank] = 8'(T_RP - 1); // [R22]
                        s_nxt.rvalid = ~s_r.q_wr;
                        s_nxt.ready = 1'b1;
                        s_nxt.st = sbr_pkg::ST_IDLE;
                    end
                end
                sbr_pkg::ST_IDLE: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            s_r <= '0;
            s_r.lrst <= 1'b1;
            s_r.st <= sbr_pkg::ST_RST;
            s_r.cmd <= sbr_pkg::CMD_NOP;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs, all from the state flop
    // ----------------------------------------
    assign link.link_clk = s_r.lclk;
    assign link.link_rst = s_r.lrst;
    assign link.cmd = s_r.cmd;
    assign link.bank = s_r.bank;
    assign link.addr = s_r.addr;
    assign link.ctl_dq_o = s_r.dq_o;
    assign link.ctl_dq_oe = s_r.dq_oe;
    assign link.write_byte_mask = s_r.dm;
    assign req_ready = s_r.ready;
    assign init_done = s_r.init;
    assign rd_valid = s_r.rvalid;
    assign rd_data = s_r.rdata;
endmodule

// ---- dv/sbr_link_sva.sv ----
`timescale 1ns/10ps
module sbr_link_sva #(
    parameter int AL = 0,
    parameter int CWL = 5,
    parameter int T_RCD = 6,
    parameter int T_RAS = 15,
    parameter int T_RP = 6,
    parameter int T_RC = 21,
    parameter int T_WR = 6,
    parameter int T_WTR = 4,
    parameter int RTP = 4
) (
    input wire logic link_clk,
    input wire logic link_rst,
    input wire sbr_pkg::sbr_cmd_e cmd,
    input wire logic [2:0] bank,
    input wire logic [13:0] addr,
    input wire logic ctl_dq_oe,
    input wire logic dev_dq_oe,
    input wire logic ts_oe
);
    typedef struct packed {
        logic [1:0] fld;
        logic [3:0] wr_beats;
        logic [7:0] act_age;
        logic [7:0] pre_age;
        logic [7:0] rd_age;
        logic [7:0] wr_age;
    } sbr_sva_s;
    sbr_sva_s r;
    sbr_sva_s n;
    logic cur_full;

    function automatic logic [7:0] sat_inc(input logic [7:0] a);
        return (a == 8'hFF) ? a : a + 8'h01;
    endfunction

    // Burst size in force for the command now on the bus
    assign cur_full = (r.fld == 2'h0) || (r.fld == 2'h3) || ((r.fld == 2'h1) && addr[12]);

    // Ages since each command kind; saturate so old history never wraps
    always_comb begin
        n = r;
        n.act_age = sat_inc(r.act_age);
        n.pre_age = sat_inc(r.pre_age);
        n.rd_age = sat_inc(r.rd_age);
        n.wr_age = sat_inc(r.wr_age);
        case (cmd)
            sbr_pkg::CMD_ACT: n.act_age = 8'h01;
            sbr_pkg::CMD_PRE: n.pre_age = 8'h01;
            sbr_pkg::CMD_RD: n.rd_age = 8'h01;
            sbr_pkg::CMD_WR: begin
                n.wr_age = 8'h01;
                n.wr_beats = cur_full ? 4'h8 : 4'h4;
            end
            sbr_pkg::CMD_MRS: if (bank == 3'h0) n.fld = addr[1:0];
            default: ;
        endcase
        // Ages start saturated so the first command is never judged against stale history
        if (link_rst) begin
            n = '1;
            n.fld = 2'h0;
        end
    end

    always_ff @(posedge link_clk) begin
        r <= n;
    end

    // ----------------------------------------
    // Link checks
    // ----------------------------------------
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (link_rst);

    a_read_full_len: assert property (cmd == sbr_pkg::CMD_RD && cur_full |->
        ##1 !dev_dq_oe [*6] ##1 dev_dq_oe [*8] ##1 !dev_dq_oe) else $error("full read burst shape wrong");
    a_read_chop_len: assert property (cmd == sbr_pkg::CMD_RD && !cur_full |->
        ##1 !dev_dq_oe [*6] ##1 dev_dq_oe [*4] ##1 !dev_dq_oe) else $error("chopped read burst shape wrong");
    a_write_full_len: assert property (cmd == sbr_pkg::CMD_WR && cur_full |->
        ##5 ctl_dq_oe [*8] ##1 !ctl_dq_oe) else $error("full write burst shape wrong");
    a_write_chop_len: assert property (cmd == sbr_pkg::CMD_WR && !cur_full |->
        ##5 ctl_dq_oe [*4] ##1 !ctl_dq_oe) else $error("chopped write burst shape wrong");
    a_read_to_close: assert property (cmd == sbr_pkg::CMD_PRE |-> r.rd_age >= AL + RTP)
        else $error("close too soon after read");
    a_open_to_close: assert property (cmd == sbr_pkg::CMD_PRE |-> r.act_age >= T_RAS)
        else $error("close too soon after activate");
    a_reopen_spacing: assert property (cmd == sbr_pkg::CMD_ACT |-> r.pre_age >= T_RP && r.act_age >= T_RC)
        else $error("activate too soon");
    a_write_recovery: assert property (cmd == sbr_pkg::CMD_PRE |-> r.wr_age >= AL + CWL + r.wr_beats + T_WR)
        else $error("close too soon after write data");
    a_write_to_read: assert property (cmd == sbr_pkg::CMD_RD |-> r.wr_age >= AL + CWL + r.wr_beats + T_WTR)
        else $error("read too soon after write data");
    a_col_after_act: assert property (cmd inside {sbr_pkg::CMD_RD, sbr_pkg::CMD_WR} |-> r.act_age >= T_RCD)
        else $error("column command too soon after activate");
    a_one_driver: assert property (!(dev_dq_oe && ctl_dq_oe))
        else $error("both ends drive the data wire");
    a_strobe_in_write: assert property (ts_oe |-> $past(ctl_dq_oe))
        else $error("termination strobe outside write beats");
endmodule

// ---- dv/sdram_burst_rw_timing_tb.sv ----
`timescale 1ns/10ps
module sdram_burst_rw_timing_tb;
    // Read-to-close delay: max(4 cycles, 7.5ns) at a 64ns link period
    localparam int RTP = 4;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [1:0] burst_field_cfg = 2'h0;
    logic termination_strobe_en_cfg = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [2:0] req_bank = 3'h5;
    logic [13:0] req_row = 14'h01A5;
    logic [9:0] req_col = 10'h000;
    logic req_chop = 1'b0;
    logic [63:0] req_wdata = 64'h0;
    logic [7:0] req_wmask = 8'h00;
    logic req_ready;
    logic init_done;
    logic rd_valid;
    logic [63:0] rd_data;
    logic [7:0] open_banks;
    logic full_burst_eight;
    logic [7:0] mem [0:15];
    logic [2:0] modes [5] = '{3'b000, 3'b010, 3'b100, 3'b011, 3'b110};
    logic [1:0] fld;
    logic termination_strobe;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int m;

    sbr_link_if link();
    sbr_mem_ctl i_sbr_mem_ctl (.sys_clk(sys_clk), .sys_rst(sys_rst), .burst_field_cfg(burst_field_cfg),
        .termination_strobe_en_cfg(termination_strobe_en_cfg), .req_valid(req_valid), .req_write(req_write), .req_bank(req_bank),
        .req_row(req_row), .req_col(req_col), .req_chop(req_chop), .req_wdata(req_wdata),
        .req_wmask(req_wmask), .req_ready(req_ready), .init_done(init_done), .rd_valid(rd_valid),
        .rd_data(rd_data), .link(link));
    sbr_dram_dev i_sbr_dram_dev (.link(link), .open_banks(open_banks), .full_burst_eight(full_burst_eight));
    sbr_link_sva #(.RTP(RTP)) i_sbr_link_sva (.link_clk(link.link_clk), .link_rst(link.link_rst),
        .cmd(link.cmd), .bank(link.bank), .addr(link.addr), .ctl_dq_oe(link.ctl_dq_oe),
        .dev_dq_oe(link.dev_dq_oe), .ts_oe(link.termination_strobe_oe));

    always #4 sys_clk = ~sys_clk;

    // Hang guard, well above twenty-five requests at about 200 cycles each
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            fail_count++;
            $display("[FAIL] %0t run timed out", $time);
            complete_run();
        end
    end

    task automatic complete_run();
        $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Own decode of the burst size, kept apart from the design's
    function automatic logic full_of(input logic sel);
        return (fld == 2'h0) || (fld == 2'h3) || ((fld == 2'h1) && sel);
    endfunction

    // ----------------------------------------
    // Request side tasks
    // ----------------------------------------
    task automatic start_mode(input logic [2:0] md);
        int i;
        @(negedge sys_clk);
        sys_rst = 1'b1;
        fld = md[2:1];
        termination_strobe = md[0];
        burst_field_cfg = fld;
        termination_strobe_en_cfg = termination_strobe;
        repeat (16) @(negedge sys_clk);
        sys_rst = 1'b0;
        for (i = 0; i < 400 && init_done !== 1'b1; i++) @(negedge sys_clk);
        check(64'(init_done), 64'h1, "init done");
    endtask

    // Ready is a level, so it is seen at a falling edge and the request is taken at the next rise
    task automatic req(input logic wr, input logic [9:0] col, input logic chop, input logic [63:0] wd,
        input logic [7:0] wm);
        int i;
        @(negedge sys_clk);
        req_valid = 1'b1;
        req_write = wr;
        req_col = col;
        req_chop = chop;
        req_wdata = wd;
        req_wmask = wm;
        for (i = 0; i < 2000 && req_ready !== 1'b1; i++) @(negedge sys_clk);
        @(negedge sys_clk);
        req_valid = 1'b0;
        for (i = 0; i < 2000 && req_ready !== 1'b0; i++) @(negedge sys_clk);
        for (i = 0; i < 2000 && (wr ? req_ready !== 1'b1 : rd_valid !== 1'b1); i++) @(negedge sys_clk);
    endtask

    task automatic wr_burst(input logic [9:0] col, input logic chop, input logic [63:0] wd, input logic [7:0] wm);
        logic full;
        logic [3:0] base;
        full = full_of(!chop);
        base = full ? {col[3], 3'b000} : {col[3:2], 2'b00};
        // Mask bit set keeps the byte, unless the pin serves as termination strobe
        for (int k = 0; k < (full ? 8 : 4); k++) begin
            if (!(wm[k] && !termination_strobe)) mem[base + 4'(k)] = wd[8*k +: 8];
        end
        req(1'b1, col, chop, wd, wm);
    endtask

    task automatic rd_burst(input logic [9:0] col, input logic chop);
        logic full;
        logic [3:0] base;
        logic [63:0] exp;
        full = full_of(!chop);
        base = full ? {col[3], 3'b000} : {col[3:2], 2'b00};
        exp = 64'h0;
        for (int k = 0; k < (full ? 8 : 4); k++) begin
            exp[8*k +: 8] = mem[base + 4'(k)];
        end
        req(1'b0, col, chop, 64'h0, 8'h00);
        check(rd_data, exp, "read data");
        @(negedge sys_clk);
        check(64'(rd_valid), 64'h0, "read valid width");
        check(64'(full_burst_eight), 64'(full), "burst size");
        repeat (40) @(negedge sys_clk);
        check(64'(open_banks), 64'h0, "rows closed");
    endtask

    // ----------------------------------------
    // Main sequence: each burst mode, one of them with masks under termination strobe
    // ----------------------------------------
    initial begin
        for (m = 0; m < 5; m++) begin
            start_mode(modes[m]);
            wr_burst(10'h000, 1'b0, 64'h0123_4567_89AB_CDEF ^ 64'(m), 8'h00);
            rd_burst(10'h000, 1'b0);
            wr_burst(10'h3F4, 1'b1, 64'hA5A5_5A5A_F00F_0FF0 ^ 64'(m), 8'h05);
            rd_burst(10'h000, 1'b0);
            rd_burst(10'h004, 1'b1);
            $display("test mode %0d done at %0t", m, $time);
        end
        complete_run();
    end
endmodule
